// *** hdl/eeprom_access_control.sv ***
// Register-side access path to the configuration memory and its shadow copy
//
// Summary of operation
// - Single write stores the write-word register at the selected memory location.
// - Single read places the addressed 16-bit memory word in the read-word register.
// - Shadow enable set: device runs from shadow values; clear: shadow unused.
// - With shadow enabled, host reads of the first SHADOW_DEPTH configuration registers from 0x90 return shadow contents.
// - Writing 1 to the resync bit copies memory contents into the shadow registers.
// - Direction bit: 0 selects read, 1 selects write.
// - Mode 00 off, 01 single, 10 mass; a host write of 11 leaves the mode unchanged.
// - Writing 1 to motor_halt stops motor control without sleeping; 0 enables.
// - motor_halt is write-only; reads never return the written value.
// - Addresses 0x37 through 0x5F hold no functional register.
// - Addresses 0x61 through 0x8F hold no functional register.
`timescale 1ns/10ps
`include "eeprom_access_defs.svh"
module eeprom_access_control #(
  parameter int SHADOW_DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire eeprom_access_pkg::regaddr_t regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire eeprom_access_pkg::word_t regWrData,
  output eeprom_access_pkg::word_t regRdData,
  input wire eeprom_access_pkg::regaddr_t singleAccessLocation,
  input wire eeprom_access_pkg::word_t cfgLiveData,
  output logic nvmReq,
  output logic nvmWriteEn,
  output eeprom_access_pkg::regaddr_t nvmAddr,
  output eeprom_access_pkg::word_t nvmWrData,
  input wire eeprom_access_pkg::word_t nvmRdData,
  input wire logic nvmAck,
  output logic useShadow,
  output logic massAccessEnable,
  output logic accessBusy,
  output logic motorHalt
);
  import eeprom_access_pkg::*;
  localparam int IDX_W = (SHADOW_DEPTH > 1) ? $clog2(SHADOW_DEPTH) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(SHADOW_DEPTH - 1);
  localparam logic [7:0] DEPTH_B = 8'(SHADOW_DEPTH);
  // Shadow window must fit between the base and the top of the map
  if (SHADOW_DEPTH < 1 || SHADOW_DEPTH > `EA_SHADOW_MAX)
  begin : g_bad_depth
    $error("SHADOW_DEPTH out of range");
  end
  word_t writeWord_reg, writeWord_next;
  word_t readWord_reg, readWord_next;
  word_t rdData_reg, rdData_next;
  logic shadowEn_reg, shadowEn_next;
  logic resync_reg, resync_next;
  logic dir_reg, dir_next;
  access_mode_e mode_reg, mode_next;
  logic halt_reg, halt_next;
  logic singlePend_reg, singlePend_next;
  xfer_state_e state_reg, state_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  regaddr_t nvmAddr_reg, nvmAddr_next;
  word_t nvmWrData_reg, nvmWrData_next;
  word_t shadow_reg [SHADOW_DEPTH];
  word_t shadow_next [SHADOW_DEPTH];
  regaddr_t cfgOff;
  logic cfgHit;
  logic resyncAck;
  logic hostCfgWr;
  word_t shadowPick;
  logic [1:0] modeField;
  assign cfgOff = regAddr - `EA_CFG_BASE;
  assign cfgHit = (regAddr >= `EA_CFG_BASE) && (cfgOff < DEPTH_B);
  assign shadowPick = shadow_reg[cfgOff[IDX_W-1:0]];
  assign resyncAck = (state_reg == ST_RESYNC) && nvmAck;
  // Host writes land in the shadow only while it is the live copy
  assign hostCfgWr = regWrEn && cfgHit && shadowEn_reg;
  assign modeField = regWrData[`EA_MODE_MSB:`EA_MODE_LSB];
  // ****************************************
  // Register file, transfer sequencer
  // ****************************************
  always_comb
  begin
    writeWord_next = writeWord_reg;
    readWord_next = readWord_reg;
    rdData_next = rdData_reg;
    shadowEn_next = shadowEn_reg;
    resync_next = resync_reg;
    dir_next = dir_reg;
    mode_next = mode_reg;
    halt_next = halt_reg;
    singlePend_next = singlePend_reg;
    state_next = state_reg;
    idx_next = idx_reg;
    nvmAddr_next = nvmAddr_reg;
    nvmWrData_next = nvmWrData_reg;
    case (state_reg)
      ST_IDLE:
        if (resync_reg)
        begin
          state_next = ST_RESYNC;
          idx_next = '0;
          nvmAddr_next = `EA_CFG_BASE;
        end
        else if (singlePend_reg)
        begin
          singlePend_next = 1'b0;
          if (mode_reg == ACC_SINGLE)
          begin
            state_next = dir_reg ? ST_WRITE : ST_READ;
            nvmAddr_next = singleAccessLocation;
            nvmWrData_next = writeWord_reg;
          end
        end
      ST_WRITE:
        if (nvmAck)
          state_next = ST_IDLE;
      ST_READ:
        if (nvmAck)
        begin
          readWord_next = nvmRdData;
          state_next = ST_IDLE;
        end
      default:
        if (nvmAck && idx_reg == LAST_IDX)
        begin
          state_next = ST_IDLE;
          resync_next = 1'b0;
        end
        else if (nvmAck)
        begin
          idx_next = idx_reg + 1'b1;
          nvmAddr_next = nvmAddr_reg + 8'h01;
        end
    endcase
    // Host writes come last so a fresh request beats the hardware clear
    if (regWrEn && regAddr == `EA_ADDR_WDATA)
      writeWord_next = regWrData;
    else if (regWrEn && regAddr == `EA_ADDR_CTRL)
    begin
      shadowEn_next = regWrData[`EA_SHADOW_BIT];
      resync_next = regWrData[`EA_RESYNC_BIT];
      dir_next = regWrData[`EA_DIR_BIT];
      if (modeField != ACC_RSVD)
        mode_next = access_mode_e'(modeField);
      if (modeField == ACC_SINGLE)
        singlePend_next = 1'b1;
    end
    else if (regWrEn && regAddr == `EA_ADDR_HALT)
      halt_next = regWrData[`EA_HALT_BIT];
    if (regRdEn)
    begin
      rdData_next = `EA_WORD_RESET;
      if (regAddr == `EA_ADDR_WDATA)
        rdData_next = writeWord_reg;
      else if (regAddr == `EA_ADDR_CTRL)
      begin
        rdData_next[`EA_SHADOW_BIT] = shadowEn_reg;
        rdData_next[`EA_RESYNC_BIT] = resync_reg;
        rdData_next[`EA_DIR_BIT] = dir_reg;
        rdData_next[`EA_MODE_MSB:`EA_MODE_LSB] = mode_reg;
      end
      else if (regAddr == `EA_ADDR_RDATA)
        rdData_next = readWord_reg;
      else if (cfgHit && shadowEn_reg)
        rdData_next = shadowPick;
      else if (regAddr >= `EA_CFG_BASE)
        rdData_next = cfgLiveData;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      writeWord_reg <= `EA_WORD_RESET;
      readWord_reg <= `EA_WORD_RESET;
      rdData_reg <= `EA_WORD_RESET;
      shadowEn_reg <= 1'b0;
      resync_reg <= 1'b0;
      dir_reg <= 1'b0;
      mode_reg <= ACC_OFF;
      halt_reg <= 1'b0;
      singlePend_reg <= 1'b0;
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      nvmAddr_reg <= `EA_ADDR_RESET;
      nvmWrData_reg <= `EA_WORD_RESET;
    end
    else
    begin
      writeWord_reg <= writeWord_next;
      readWord_reg <= readWord_next;
      rdData_reg <= rdData_next;
      shadowEn_reg <= shadowEn_next;
      resync_reg <= resync_next;
      dir_reg <= dir_next;
      mode_reg <= mode_next;
      halt_reg <= halt_next;
      singlePend_reg <= singlePend_next;
      state_reg <= state_next;
      idx_reg <= idx_next;
      nvmAddr_reg <= nvmAddr_next;
      nvmWrData_reg <= nvmWrData_next;
    end
  end
  // ****************************************
  // Shadow copy
  // ****************************************
  for (genvar i = 0; i < SHADOW_DEPTH; i++)
  begin : g_shadow
    always_comb
    begin
      shadow_next[i] = shadow_reg[i];
      if (resyncAck && idx_reg == IDX_W'(i))
        shadow_next[i] = nvmRdData;
      else if (hostCfgWr && cfgOff[IDX_W-1:0] == IDX_W'(i))
        shadow_next[i] = regWrData;
    end
    always_ff @(posedge clk)
    begin
      if (srst)
        shadow_reg[i] <= `EA_WORD_RESET;
      else
        shadow_reg[i] <= shadow_next[i];
    end
  end
  assign regRdData = rdData_reg;
  assign nvmReq = (state_reg != ST_IDLE);
  assign nvmWriteEn = (state_reg == ST_WRITE);
  assign nvmAddr = nvmAddr_reg;
  assign nvmWrData = nvmWrData_reg;
  assign useShadow = shadowEn_reg;
  assign massAccessEnable = (mode_reg == ACC_MASS);
  assign accessBusy = (state_reg != ST_IDLE);
  assign motorHalt = halt_reg;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_halt_write;
    regWrEn && regAddr == `EA_ADDR_HALT |=> motorHalt == $past(regWrData[`EA_HALT_BIT]);
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("halt not taken");
  property p_halt_hidden;
    regRdEn && regAddr == `EA_ADDR_HALT |=> regRdData == `EA_WORD_RESET;
  endproperty
  a_halt_hidden: assert property (p_halt_hidden) else $error("halt readable");
  property p_unused_low;
    regRdEn && regAddr >= `EA_UNUSED1_LO && regAddr <= `EA_UNUSED1_HI
      |=> regRdData == `EA_WORD_RESET;
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("low hole not zero");
  property p_unused_high;
    regRdEn && regAddr >= `EA_UNUSED2_LO && regAddr <= `EA_UNUSED2_HI
      |=> regRdData == `EA_WORD_RESET;
  endproperty
  a_unused_high: assert property (p_unused_high) else $error("high hole not zero");
  property p_write_word;
    state_reg == ST_IDLE ##1 state_reg == ST_WRITE |-> nvmWrData == $past(writeWord_reg);
  endproperty
  a_write_word: assert property (p_write_word) else $error("wrong write word");
  property p_read_word;
    state_reg == ST_READ && nvmAck ##1 regRdEn && regAddr == `EA_ADDR_RDATA
      |=> regRdData == $past(nvmRdData, 2);
  endproperty
  a_read_word: assert property (p_read_word) else $error("read word lost");
  property p_direction;
    $rose(nvmReq) && state_reg != ST_RESYNC |-> nvmWriteEn == $past(dir_reg);
  endproperty
  a_direction: assert property (p_direction) else $error("wrong direction");
  property p_shadow_read;
    regRdEn && cfgHit && useShadow |=> regRdData == $past(shadowPick);
  endproperty
  a_shadow_read: assert property (p_shadow_read) else $error("shadow not returned");
  property p_mode_rsvd;
    regWrEn && regAddr == `EA_ADDR_CTRL && modeField == ACC_RSVD |=> $stable(mode_reg);
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode 11 taken");
  property p_resync_start;
    state_reg == ST_IDLE && resync_reg |=> state_reg == ST_RESYNC && nvmAddr == `EA_CFG_BASE;
  endproperty
  a_resync_start: assert property (p_resync_start) else $error("resync not started");
  // A request already pending would be served one cycle earlier
  property p_single_start;
    regWrEn && regAddr == `EA_ADDR_CTRL && modeField == ACC_SINGLE && state_reg == ST_IDLE
      && !resync_reg && !singlePend_reg && !regWrData[`EA_RESYNC_BIT]
      |=> ##1 nvmReq && nvmAddr == $past(singleAccessLocation);
  endproperty
  a_single_start: assert property (p_single_start) else $error("single not started");

  c_single_write: cover property (state_reg == ST_WRITE && nvmAck);
  c_single_read: cover property (state_reg == ST_READ && nvmAck);
  c_resync_done: cover property (resyncAck && idx_reg == LAST_IDX);
  c_halt_set: cover property ($rose(motorHalt));
endmodule : eeprom_access_control

// *** hdl/eeprom_access_defs.svh ***
// Register offsets, field positions and reset values for the nonvolatile access path
`ifndef EEPROM_ACCESS_DEFS_SVH
`define EEPROM_ACCESS_DEFS_SVH
`define EA_ADDR_WDATA 8'h34
`define EA_ADDR_CTRL 8'h35
`define EA_ADDR_RDATA 8'h36
`define EA_UNUSED1_LO 8'h37
`define EA_UNUSED1_HI 8'h5F
`define EA_ADDR_HALT 8'h60
`define EA_UNUSED2_LO 8'h61
`define EA_UNUSED2_HI 8'h8F
`define EA_CFG_BASE 8'h90
`define EA_SHADOW_MAX 112
`define EA_SHADOW_BIT 12
`define EA_RESYNC_BIT 8
`define EA_DIR_BIT 2
`define EA_MODE_MSB 1
`define EA_MODE_LSB 0
`define EA_HALT_BIT 15
`define EA_WORD_RESET 16'h0000
`define EA_ADDR_RESET 8'h00
`endif

// *** hdl/eeprom_access_pkg.sv ***
// Types shared by the nonvolatile access path
package eeprom_access_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] regaddr_t;
  typedef enum logic [1:0] {
    ACC_OFF = 2'b00,
    ACC_SINGLE = 2'b01,
    ACC_MASS = 2'b10,
    ACC_RSVD = 2'b11
  } access_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10,
    ST_RESYNC = 2'b11
  } xfer_state_e;
endpackage : eeprom_access_pkg

// *** dv/nvm_model.sv ***
// Behavioural configuration memory answering the request port
`timescale 1ns/10ps
module nvm_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic nvmReq,
  input wire logic nvmWriteEn,
  input wire eeprom_access_pkg::regaddr_t nvmAddr,
  input wire eeprom_access_pkg::word_t nvmWrData,
  input wire logic [1:0] ackDelay,
  output logic nvmAck,
  output eeprom_access_pkg::word_t nvmRdData
);
  import eeprom_access_pkg::*;
  word_t mem [256];
  logic [1:0] waitCnt;
  initial
  begin
    nvmAck = 1'b0;
    nvmRdData = 16'h0000;
    for (int i = 0; i < 256; i++)
      mem[i] = {8'hC3, 8'(i)};
  end
  // Data line churns outside ack, so a stale word never looks valid
  always @(posedge clk)
  begin
    nvmAck <= 1'b0;
    nvmRdData <= ~nvmRdData;
    if (srst)
      waitCnt <= 2'h0;
    else if (nvmReq && !nvmAck && waitCnt == ackDelay)
    begin
      nvmAck <= 1'b1;
      waitCnt <= 2'h0;
      nvmRdData <= mem[nvmAddr];
      if (nvmWriteEn)
        mem[nvmAddr] <= nvmWrData;
    end
    else if (nvmReq && !nvmAck)
      waitCnt <= waitCnt + 2'h1;
  end
endmodule : nvm_model

// *** dv/tb_eeprom_access_control.sv ***
// Self-checking bench for the configuration memory access path
`timescale 1ns/10ps
module tb_eeprom_access_control;
  import eeprom_access_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  regaddr_t regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  word_t regWrData = 16'h0000;
  regaddr_t loc = 8'h00;
  word_t cfgLive = 16'h5A5A;
  logic [1:0] ackDelay = 2'h0;
  word_t regRdData, nvmWrData, nvmRdData;
  regaddr_t nvmAddr;
  logic nvmReq, nvmWriteEn, nvmAck, useShadow, massEn, busy, motorHalt;
  int errors = 0;
  int checks_done = 0;
  word_t modeIn [3] = '{16'h0000, 16'h0002, 16'h0003};
  word_t modeExp [3] = '{16'h0000, 16'h0002, 16'h0002};
  always #12.5 clk = ~clk;
  eeprom_access_control #(.SHADOW_DEPTH(2)) u_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .singleAccessLocation(loc), .cfgLiveData(cfgLive), .nvmReq(nvmReq),
    .nvmWriteEn(nvmWriteEn), .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .nvmRdData(nvmRdData),
    .nvmAck(nvmAck), .useShadow(useShadow), .massAccessEnable(massEn), .accessBusy(busy),
    .motorHalt(motorHalt));
  nvm_model u_mem (.clk(clk), .srst(srst), .nvmReq(nvmReq), .nvmWriteEn(nvmWriteEn),
    .nvmAddr(nvmAddr), .nvmWrData(nvmWrData), .ackDelay(ackDelay), .nvmAck(nvmAck),
    .nvmRdData(nvmRdData));
  // ****************
  // Access tasks
  // ****************
  task summarize;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task chk(input word_t got, input word_t exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle, launched on the falling edge
  task wr(input regaddr_t a, input word_t d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr
  task rd(input regaddr_t a, input word_t exp);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    @(negedge clk);
    chk(regRdData, exp);
  endtask : rd
  // Request must rise exactly two cycles after the control write
  task runAcc(input word_t ctrl);
    wr(8'h35, ctrl);
    chk({15'h0, busy}, 16'h0000);
    @(negedge clk);
    chk({15'h0, busy}, 16'h0001);
    for (int i = 0; i < 40 && busy; i++)
      @(negedge clk);
    chk({15'h0, busy}, 16'h0000);
  endtask : runAcc
  // ****************
  // Test sequence
  // ****************
  initial
  begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    rd(8'h34, 16'h0000);
    rd(8'h35, 16'h0000);
    rd(8'h36, 16'h0000);
    rd(8'h60, 16'h0000);
    wr(8'h60, 16'h8000);
    chk({15'h0, motorHalt}, 16'h0001);
    rd(8'h60, 16'h0000);
    wr(8'h34, 16'hBEEF);
    rd(8'h34, 16'hBEEF);
    wr(8'h36, 16'h1234);
    rd(8'h36, 16'h0000);
    foreach (modeIn[i])
    begin
      wr(8'h37 + 8'(i * 8'h28), 16'hFFFF);
      rd(8'h37 + 8'(i * 8'h28), 16'h0000);
    end
    wr(8'h8F, 16'hFFFF);
    rd(8'h8F, 16'h0000);
    loc = 8'h91;
    runAcc(16'h0005);
    chk(u_mem.mem[8'h91], 16'hBEEF);
    rd(8'h35, 16'h0005);
    loc = 8'h92;
    runAcc(16'h0001);
    rd(8'h36, 16'hC392);
    foreach (modeIn[i])
    begin
      wr(8'h35, modeIn[i]);
      rd(8'h35, modeExp[i]);
      chk({15'h0, massEn}, {15'h0, modeExp[i][1]});
    end
    // Slow memory during the shadow copy
    ackDelay = 2'h3;
    runAcc(16'h0100);
    rd(8'h35, 16'h0000);
    wr(8'h35, 16'h1000);
    chk({15'h0, useShadow}, 16'h0001);
    rd(8'h90, 16'hC390);
    rd(8'h91, 16'hBEEF);
    rd(8'h92, 16'h5A5A);
    wr(8'h91, 16'h1357);
    rd(8'h91, 16'h1357);
    wr(8'h35, 16'h0000);
    chk({15'h0, useShadow}, 16'h0000);
    rd(8'h90, 16'h5A5A);
    wr(8'h60, 16'h0000);
    chk({15'h0, motorHalt}, 16'h0000);
    // Mid-run reset must clear every control bit
    wr(8'h35, 16'h1002);
    rd(8'h35, 16'h1002);
    wr(8'h60, 16'h8000);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk({useShadow, massEn, motorHalt, 13'h0}, 16'h0000);
    rd(8'h35, 16'h0000);
    summarize();
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : tb_eeprom_access_control
